// ===== core/cesd_pkg.sv
// package: register map, field positions, reset values and event codes of the diagnostics block
package cesd_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the avalon slave
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_ERROR_COUNT_STATUS = 4'h0;  // counters and confinement state
  localparam logic [3:0] OFS_BUS_DIAG_COUNTERS = 4'h4;  // per-phase error counters
  localparam logic [3:0] OFS_BUS_DIAG_FLAGS_MSGCOUNT = 4'h8;  // sticky flags and message count

  // ----------------------------------------------------------------
  // avalon response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;  // access done
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // unmapped address

  // ----------------------------------------------------------------
  // confinement thresholds
  // ----------------------------------------------------------------
  localparam logic [8:0] TEC_BUS_OFF_ABOVE = 9'h0ff;  // bus-off when counter exceeds this
  localparam logic [8:0] PASSIVE_ABOVE = 9'h07f;  // error-passive when above this
  localparam logic [8:0] WARN_ABOVE = 9'h05f;  // warning when above this
  localparam logic [8:0] WARN_BELOW = 9'h080;  // and below this
  localparam logic [8:0] ERR_STEP_BIG = 9'h008;  // increment for a serious error
  localparam logic [8:0] ERR_STEP_ONE = 9'h001;  // increment or decrement by one
  localparam logic [8:0] ERR_ZERO = 9'h000;  // cleared counter

  // ----------------------------------------------------------------
  // status word field positions
  // ----------------------------------------------------------------
  localparam int BIT_TX_BUS_OFF = 21;  // tx_bus_off_flag
  localparam int BIT_TX_PASSIVE = 20;  // tx_error_passive_flag
  localparam int BIT_RX_PASSIVE = 19;  // rx_error_passive_flag
  localparam int BIT_TX_WARN = 18;  // tx_warning_flag
  localparam int BIT_RX_WARN = 17;  // rx_warning_flag
  localparam int BIT_ANY_WARN = 16;  // any_warning_flag

  // ----------------------------------------------------------------
  // sticky flag positions within the upper half of the flags register
  // ----------------------------------------------------------------
  localparam int FL_LEN_MISMATCH = 15;  // length_mismatch_flag
  localparam int FL_ESI = 14;  // error_state_indicator_flag
  localparam int FL_D_CRC = 13;  // data_phase_checksum_err
  localparam int FL_D_STUFF = 12;  // data_phase_stuffing_err
  localparam int FL_D_FORM = 11;  // data_phase_format_err
  localparam int FL_D_BIT1 = 9;  // data_phase_recessive_err
  localparam int FL_D_BIT0 = 8;  // data_phase_dominant_err
  localparam int FL_BUS_OFF_EVT = 7;  // bus_off_recovered_event
  localparam int FL_N_CRC = 5;  // nominal_checksum_err
  localparam int FL_N_STUFF = 4;  // nominal_stuffing_err
  localparam int FL_N_FORM = 3;  // nominal_format_err
  localparam int FL_N_ACK = 2;  // missing_acknowledge_err
  localparam int FL_N_BIT1 = 1;  // nominal_recessive_err
  localparam int FL_N_BIT0 = 0;  // nominal_dominant_err
  localparam logic [15:0] FLAG_IMPL_MASK = 16'hfbbf;  // two unused positions stay zero

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] STATUS_RESET = 6'h20;  // bus-off flag set at power-on
  localparam logic [7:0] BYTE_ZERO = 8'h00;  // cleared byte counter
  localparam logic [15:0] HALF_ZERO = 16'h0000;  // cleared half word

  // ----------------------------------------------------------------
  // protocol error types reported by the protocol engine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ERR_CRC,
    ERR_STUFF,
    ERR_FORM,
    ERR_ACK,
    ERR_BIT1,
    ERR_BIT0
  } cesd_err_type;

endpackage

// ===== core/cesd_diag.sv
// module: error confinement state and bus diagnostics of a can fd controller, avalon slave
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
//
// Overview of operation
// - bus-off flag set when tx counter exceeds 255
// - bus-off reads set in configuration mode, resets one
// - tx passive flag when tx counter above 127
// - rx passive flag when rx counter above 127
// - tx warning when tx counter within 96..127
// - rx warning when rx counter within 96..127
// - combined warning is tx or rx warning
// - status word shows tx and rx counters
// - data phase tx/rx error counters, upper bytes
// - nominal tx/rx error counters, lower bytes
// - flag length code larger than payload size
// - flag received frame with error state indicator
// - data phase crc/stuff/form/bit error flags
// - flag bus-off entered and auto recovered
// - flag nominal received checksum mismatch
// - flag more than five equal bits
// - flag illegal fixed format field
// - flag transmitted frame not acknowledged
// - flag sent recessive but saw dominant
// - flag sent dominant but saw recessive
// - 16-bit error free message counter, read/write
// - unused bits read zero, writes ignored
module cesd_diag #(
  parameter logic [8:0] REC_PASSIVE_RETURN = 9'h078  // rx counter after success while passive
) (
  input wire logic clk_sys_i,  // 250 mhz system clock
  input wire logic resetn_i,  // synchronous reset, active low
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,  // byte address
  input wire logic avs_read_i,  // read request
  input wire logic avs_write_i,  // write request
  input wire logic [31:0] avs_writedata_i,  // write data
  input wire logic [3:0] avs_byteenable_i,  // byte lanes
  output logic [31:0] avs_readdata_o,  // read data
  output logic [1:0] avs_response_o,  // okay or slave error
  output logic avs_waitrequest_o,  // high until the answer
  // protocol engine inputs: event pulses of one cycle on this clock, the configuration mode level and error qualifiers
  input wire logic config_mode_i,  // controller in configuration mode
  input wire logic tx_err_i,  // transmit error seen
  input wire logic tx_ok_i,  // frame sent successfully
  input wire logic rx_err_i,  // receive error seen
  input wire logic rx_err_big_i,  // receive error counted as eight
  input wire logic rx_ok_i,  // frame received successfully
  input wire logic bus_off_recover_i,  // recovery sequence completed
  input wire logic err_valid_i,  // protocol error reported
  input wire cesd_pkg::cesd_err_type err_type_i,  // kind of protocol error
  input wire logic err_data_phase_i,  // error lies in the data phase
  input wire logic err_is_tx_i,  // node was transmitter
  input wire logic len_mismatch_i,  // length code above payload size
  input wire logic esi_rx_i,  // received fd frame with esi set
  input wire logic msg_ok_i,  // message completed without error
  // confinement state to the rest of the controller
  output logic tx_bus_off_o,  // node is bus-off
  output logic tx_error_passive_o,  // transmitter error-passive
  output logic rx_error_passive_o,  // receiver error-passive
  output logic any_warning_o  // any warning state
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [8:0] tx_error_counter_ff;  // tx counter, ninth bit marks bus-off
  logic [8:0] nxt_tx_error_counter;
  logic [8:0] rx_error_counter_ff;  // rx counter, saturates at 255
  logic [8:0] nxt_rx_error_counter;
  logic [5:0] status_ff;  // bus-off, passive and warning flags
  logic [5:0] nxt_status;
  logic [7:0] data_phase_tx_err_count_ff;  // data phase tx errors
  logic [7:0] nxt_data_phase_tx_err_count;
  logic [7:0] data_phase_rx_err_count_ff;  // data phase rx errors
  logic [7:0] nxt_data_phase_rx_err_count;
  logic [7:0] nominal_tx_err_count_ff;  // nominal phase tx errors
  logic [7:0] nxt_nominal_tx_err_count;
  logic [7:0] nominal_rx_err_count_ff;  // nominal phase rx errors
  logic [7:0] nxt_nominal_rx_err_count;
  logic [15:0] diag_flags_ff;  // sticky error flags
  logic [15:0] nxt_diag_flags;
  logic [15:0] error_free_msg_counter_ff;  // error free messages
  logic [15:0] nxt_error_free_msg_counter;
  logic [31:0] avs_readdata_ff;  // registered read data
  logic [31:0] nxt_avs_readdata;
  logic [1:0] avs_response_ff;  // registered response
  logic [1:0] nxt_avs_response;
  logic avs_waitrequest_ff;  // registered waitrequest
  logic nxt_avs_waitrequest;
  logic wr_commit;  // write takes effect on this edge
  logic wr_status;  // write hits the status word
  logic wr_counters;  // write hits the per-phase counters
  logic wr_flags;  // write hits flags and message count
  logic [31:0] wr_bits;  // byte enables spread to bits
  logic bus_off_now;  // tx counter beyond the bus-off limit

  // ----------------------------------------------------------------
  // write decode, used by the counter and flag register groups
  // ----------------------------------------------------------------
  // a write is applied only on the edge where waitrequest is seen low
  assign wr_commit = avs_write_i && !avs_waitrequest_ff;
  assign wr_status = wr_commit && (avs_address_i == cesd_pkg::OFS_ERROR_COUNT_STATUS);
  assign wr_counters = wr_commit && (avs_address_i == cesd_pkg::OFS_BUS_DIAG_COUNTERS);
  assign wr_flags = wr_commit && (avs_address_i == cesd_pkg::OFS_BUS_DIAG_FLAGS_MSGCOUNT);
  assign wr_bits = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign bus_off_now = tx_error_counter_ff > cesd_pkg::TEC_BUS_OFF_ABOVE;

  // ----------------------------------------------------------------
  // confinement counters and state flags
  // ----------------------------------------------------------------
  // counters move on protocol events; a bus-off node freezes its tx
  // counter until the recovery sequence clears both counters
  always_comb begin
    nxt_tx_error_counter = tx_error_counter_ff;
    nxt_rx_error_counter = rx_error_counter_ff;
    if (bus_off_recover_i && bus_off_now) begin
      // recovery restarts both counters from zero
      nxt_tx_error_counter = cesd_pkg::ERR_ZERO;
      nxt_rx_error_counter = cesd_pkg::ERR_ZERO;
    end else begin
      if (!bus_off_now) begin
        // tx: error adds eight, success takes one
        if (tx_err_i) begin
          nxt_tx_error_counter = tx_error_counter_ff + cesd_pkg::ERR_STEP_BIG;
        end else if (tx_ok_i && (tx_error_counter_ff != cesd_pkg::ERR_ZERO)) begin
          nxt_tx_error_counter = tx_error_counter_ff - cesd_pkg::ERR_STEP_ONE;
        end
      end
      if (rx_err_big_i) begin
        // rx: serious error adds eight, saturating
        nxt_rx_error_counter = rx_error_counter_ff + cesd_pkg::ERR_STEP_BIG;
      end else if (rx_err_i) begin
        nxt_rx_error_counter = rx_error_counter_ff + cesd_pkg::ERR_STEP_ONE;
      end else if (rx_ok_i) begin
        if (rx_error_counter_ff > cesd_pkg::PASSIVE_ABOVE) begin
          // leaving error-passive drops to a fixed value
          nxt_rx_error_counter = REC_PASSIVE_RETURN;
        end else if (rx_error_counter_ff != cesd_pkg::ERR_ZERO) begin
          nxt_rx_error_counter = rx_error_counter_ff - cesd_pkg::ERR_STEP_ONE;
        end
      end
      if (nxt_rx_error_counter > cesd_pkg::TEC_BUS_OFF_ABOVE) begin
        // the rx counter has no bus-off meaning, keep it in one byte
        nxt_rx_error_counter = cesd_pkg::TEC_BUS_OFF_ABOVE;
      end
    end
    // state flags follow the next counter values so both stand together
    nxt_status[5] = config_mode_i ||
                    (nxt_tx_error_counter > cesd_pkg::TEC_BUS_OFF_ABOVE);
    nxt_status[4] = nxt_tx_error_counter > cesd_pkg::PASSIVE_ABOVE;
    nxt_status[3] = nxt_rx_error_counter > cesd_pkg::PASSIVE_ABOVE;
    nxt_status[2] = (nxt_tx_error_counter > cesd_pkg::WARN_ABOVE) &&
                    (nxt_tx_error_counter < cesd_pkg::WARN_BELOW);
    nxt_status[1] = (nxt_rx_error_counter > cesd_pkg::WARN_ABOVE) &&
                    (nxt_rx_error_counter < cesd_pkg::WARN_BELOW);
    nxt_status[0] = nxt_status[2] || nxt_status[1];
  end

  // registers the confinement group; bus-off flag comes up set
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tx_error_counter_ff <= cesd_pkg::ERR_ZERO;
      rx_error_counter_ff <= cesd_pkg::ERR_ZERO;
      status_ff <= cesd_pkg::STATUS_RESET;
    end else begin
      tx_error_counter_ff <= nxt_tx_error_counter;
      rx_error_counter_ff <= nxt_rx_error_counter;
      status_ff <= nxt_status;
    end
  end

  // ----------------------------------------------------------------
  // per-phase error counters and error free message counter
  // ----------------------------------------------------------------
  // each counter saturates; a software write to its byte wins over a count
  always_comb begin
    nxt_data_phase_tx_err_count = data_phase_tx_err_count_ff;
    nxt_data_phase_rx_err_count = data_phase_rx_err_count_ff;
    nxt_nominal_tx_err_count = nominal_tx_err_count_ff;
    nxt_nominal_rx_err_count = nominal_rx_err_count_ff;
    nxt_error_free_msg_counter = error_free_msg_counter_ff;
    if (err_valid_i) begin
      // one count per reported error, sorted by phase and role
      if (err_data_phase_i && err_is_tx_i) begin
        if (data_phase_tx_err_count_ff != 8'hff) begin
          nxt_data_phase_tx_err_count = data_phase_tx_err_count_ff + 8'h01;
        end
      end else if (err_data_phase_i) begin
        if (data_phase_rx_err_count_ff != 8'hff) begin
          nxt_data_phase_rx_err_count = data_phase_rx_err_count_ff + 8'h01;
        end
      end else if (err_is_tx_i) begin
        if (nominal_tx_err_count_ff != 8'hff) begin
          nxt_nominal_tx_err_count = nominal_tx_err_count_ff + 8'h01;
        end
      end else begin
        if (nominal_rx_err_count_ff != 8'hff) begin
          nxt_nominal_rx_err_count = nominal_rx_err_count_ff + 8'h01;
        end
      end
    end
    if (msg_ok_i && (error_free_msg_counter_ff != 16'hffff)) begin
      nxt_error_free_msg_counter = error_free_msg_counter_ff + 16'h0001;
    end
    if (wr_counters) begin
      // byte-wise overwrite by software
      if (avs_byteenable_i[3]) begin
        nxt_data_phase_tx_err_count = avs_writedata_i[31:24];
      end
      if (avs_byteenable_i[2]) begin
        nxt_data_phase_rx_err_count = avs_writedata_i[23:16];
      end
      if (avs_byteenable_i[1]) begin
        nxt_nominal_tx_err_count = avs_writedata_i[15:8];
      end
      if (avs_byteenable_i[0]) begin
        nxt_nominal_rx_err_count = avs_writedata_i[7:0];
      end
    end
    if (wr_flags) begin
      // message counter is software writable per byte
      if (avs_byteenable_i[1]) begin
        nxt_error_free_msg_counter[15:8] = avs_writedata_i[15:8];
      end
      if (avs_byteenable_i[0]) begin
        nxt_error_free_msg_counter[7:0] = avs_writedata_i[7:0];
      end
    end
  end

  // registers the diagnostic counter group
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      data_phase_tx_err_count_ff <= cesd_pkg::BYTE_ZERO;
      data_phase_rx_err_count_ff <= cesd_pkg::BYTE_ZERO;
      nominal_tx_err_count_ff <= cesd_pkg::BYTE_ZERO;
      nominal_rx_err_count_ff <= cesd_pkg::BYTE_ZERO;
      error_free_msg_counter_ff <= cesd_pkg::HALF_ZERO;
    end else begin
      data_phase_tx_err_count_ff <= nxt_data_phase_tx_err_count;
      data_phase_rx_err_count_ff <= nxt_data_phase_rx_err_count;
      nominal_tx_err_count_ff <= nxt_nominal_tx_err_count;
      nominal_rx_err_count_ff <= nxt_nominal_rx_err_count;
      error_free_msg_counter_ff <= nxt_error_free_msg_counter;
    end
  end

  // ----------------------------------------------------------------
  // sticky protocol error flags
  // ----------------------------------------------------------------
  // writing zero clears a flag, writing one leaves it; a new event in
  // the same cycle as the clear keeps the flag set
  always_comb begin
    logic [15:0] flag_set;  // events raising flags this cycle
    logic [15:0] flag_clr;  // flags cleared by software this cycle
    flag_set = cesd_pkg::HALF_ZERO;
    flag_clr = cesd_pkg::HALF_ZERO;
    flag_set[cesd_pkg::FL_LEN_MISMATCH] = len_mismatch_i;
    flag_set[cesd_pkg::FL_ESI] = esi_rx_i;
    flag_set[cesd_pkg::FL_BUS_OFF_EVT] = bus_off_recover_i && bus_off_now;
    if (err_valid_i) begin
      if (err_data_phase_i) begin
        // data phase copies of the nominal checks
        case (err_type_i)
          cesd_pkg::ERR_CRC: flag_set[cesd_pkg::FL_D_CRC] = 1'b1;
          cesd_pkg::ERR_STUFF: flag_set[cesd_pkg::FL_D_STUFF] = 1'b1;
          cesd_pkg::ERR_FORM: flag_set[cesd_pkg::FL_D_FORM] = 1'b1;
          cesd_pkg::ERR_BIT1: flag_set[cesd_pkg::FL_D_BIT1] = 1'b1;
          cesd_pkg::ERR_BIT0: flag_set[cesd_pkg::FL_D_BIT0] = 1'b1;
          default: flag_set[cesd_pkg::FL_N_ACK] = (err_type_i == cesd_pkg::ERR_ACK);
        endcase
      end else begin
        // nominal rate checks
        case (err_type_i)
          cesd_pkg::ERR_CRC: flag_set[cesd_pkg::FL_N_CRC] = 1'b1;
          cesd_pkg::ERR_STUFF: flag_set[cesd_pkg::FL_N_STUFF] = 1'b1;
          cesd_pkg::ERR_FORM: flag_set[cesd_pkg::FL_N_FORM] = 1'b1;
          cesd_pkg::ERR_ACK: flag_set[cesd_pkg::FL_N_ACK] = 1'b1;
          cesd_pkg::ERR_BIT1: flag_set[cesd_pkg::FL_N_BIT1] = 1'b1;
          cesd_pkg::ERR_BIT0: flag_set[cesd_pkg::FL_N_BIT0] = 1'b1;
          default: flag_set[cesd_pkg::FL_N_FORM] = 1'b0;
        endcase
      end
    end
    if (wr_flags) begin
      // zero written under an enabled byte lane clears
      flag_clr = wr_bits[31:16] & ~avs_writedata_i[31:16];
    end
    nxt_diag_flags = ((diag_flags_ff & ~flag_clr) | flag_set) &
                     cesd_pkg::FLAG_IMPL_MASK;
  end

  // registers the sticky flag group
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      diag_flags_ff <= cesd_pkg::HALF_ZERO;
    end else begin
      diag_flags_ff <= nxt_diag_flags;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then a one-cycle answer
  // ----------------------------------------------------------------
  // waitrequest rests high; a request drops it for one cycle with the
  // read data and response already registered
  always_comb begin
    nxt_avs_waitrequest = 1'b1;
    nxt_avs_readdata = avs_readdata_ff;
    nxt_avs_response = avs_response_ff;
    if ((avs_read_i || avs_write_i) && avs_waitrequest_ff) begin
      // request seen: prepare the answer
      nxt_avs_waitrequest = 1'b0;
      nxt_avs_readdata = 32'h0000_0000;
      nxt_avs_response = cesd_pkg::RESP_OKAY;
      case (avs_address_i)
        cesd_pkg::OFS_ERROR_COUNT_STATUS: begin
          // read-only word, writes ignored; upper bits read zero
          nxt_avs_readdata[cesd_pkg::BIT_TX_BUS_OFF] = status_ff[5];
          nxt_avs_readdata[cesd_pkg::BIT_TX_PASSIVE] = status_ff[4];
          nxt_avs_readdata[cesd_pkg::BIT_RX_PASSIVE] = status_ff[3];
          nxt_avs_readdata[cesd_pkg::BIT_TX_WARN] = status_ff[2];
          nxt_avs_readdata[cesd_pkg::BIT_RX_WARN] = status_ff[1];
          nxt_avs_readdata[cesd_pkg::BIT_ANY_WARN] = status_ff[0];
          nxt_avs_readdata[15:8] = tx_error_counter_ff[7:0];
          nxt_avs_readdata[7:0] = rx_error_counter_ff[7:0];
        end
        cesd_pkg::OFS_BUS_DIAG_COUNTERS: begin
          nxt_avs_readdata = {data_phase_tx_err_count_ff, data_phase_rx_err_count_ff,
                              nominal_tx_err_count_ff, nominal_rx_err_count_ff};
        end
        cesd_pkg::OFS_BUS_DIAG_FLAGS_MSGCOUNT: begin
          nxt_avs_readdata = {diag_flags_ff, error_free_msg_counter_ff};
        end
        default: begin
          // unmapped address answers with an error and zero data
          nxt_avs_response = cesd_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // registers the bus answer group
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      avs_waitrequest_ff <= 1'b1;
      avs_readdata_ff <= 32'h0000_0000;
      avs_response_ff <= cesd_pkg::RESP_OKAY;
    end else begin
      avs_waitrequest_ff <= nxt_avs_waitrequest;
      avs_readdata_ff <= nxt_avs_readdata;
      avs_response_ff <= nxt_avs_response;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign avs_waitrequest_o = avs_waitrequest_ff;
  assign avs_readdata_o = avs_readdata_ff;
  assign avs_response_o = avs_response_ff;
  assign tx_bus_off_o = status_ff[5];
  assign tx_error_passive_o = status_ff[4];
  assign rx_error_passive_o = status_ff[3];
  assign any_warning_o = status_ff[0];

endmodule

// ===== tb/cesd_can_node.sv
// partner: protocol engine events as the can bus side would raise them
`timescale 1ns/1ns
module cesd_can_node (
  input wire logic clk_sys_i,  // system clock
  output logic [9:0] ev_o = 10'h000,  // one strobe per event kind
  output cesd_pkg::cesd_err_type err_type_o = cesd_pkg::ERR_CRC,  // protocol error kind
  output logic err_dp_o = 1'b0,  // error in the data phase
  output logic err_tx_o = 1'b0  // node was transmitter
);
  // n one-cycle strobes on event b, an idle cycle between them
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge clk_sys_i) ev_o[b] <= 1'b1;
      @(posedge clk_sys_i) ev_o[b] <= 1'b0;
    end
  endtask
  // qualifiers settle one cycle ahead of the valid strobe
  task automatic perr(input cesd_pkg::cesd_err_type t, input logic dp, input logic tx);
    @(posedge clk_sys_i) err_type_o <= t;
    err_dp_o <= dp;
    err_tx_o <= tx;
    pulse(7, 1);
  endtask
endmodule

// ===== tb/cesd_diag_sva.sv
// checker: handshake and confinement state relations at the block ports
`timescale 1ns/1ns
module cesd_diag_chk (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic config_mode_i,
  input wire logic tx_err_i,
  input wire logic rx_err_i,
  input wire logic rx_err_big_i,
  input wire logic bus_off_recover_i,
  input wire logic tx_bus_off_o,
  input wire logic tx_error_passive_o,
  input wire logic rx_error_passive_o,
  input wire logic any_warning_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  answer_time_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered after one wait cycle");
  idle_wait_a: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("answer without a request");
  config_off_a: assert property (config_mode_i |=> tx_bus_off_o)
    else $error("bus-off not shown in configuration mode");
  off_passive_a: assert property (tx_bus_off_o && !$past(config_mode_i) && $past(resetn_i)
    |-> tx_error_passive_o) else $error("bus-off without error-passive");
  recover_a: assert property (bus_off_recover_i && tx_bus_off_o && !config_mode_i
    && !$past(config_mode_i) |=> !tx_bus_off_o && !tx_error_passive_o && !rx_error_passive_o
    && !any_warning_o) else $error("state not cleared by recovery");
  tx_rise_a: assert property ($rose(tx_error_passive_o) |-> $past(tx_err_i))
    else $error("tx passive without tx error");
  rx_rise_a: assert property ($rose(rx_error_passive_o)
    |-> $past(rx_err_i || rx_err_big_i)) else $error("rx passive without rx error");
endmodule
bind cesd_diag cesd_diag_chk i_cesd_diag_chk (.*);

// ===== tb/cesd_diag_tb_top.sv
// testbench: register scenarios for the diagnostics block
`timescale 1ns/1ns
module cesd_diag_tb_top;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cfg = 1'b1;  // configuration mode level
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic wreq;
  logic [9:0] ev;
  cesd_pkg::cesd_err_type ety;
  logic edp;
  logic etx;
  logic [3:0] sto;  // bus-off, tx passive, rx passive and warning outputs
  int bad_count = 0;
  int num_checks = 0;
  cesd_diag i_cesd_diag (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_response_o(resp), .avs_waitrequest_o(wreq),
    .config_mode_i(cfg), .tx_err_i(ev[0]), .tx_ok_i(ev[1]), .rx_err_i(ev[2]),
    .rx_err_big_i(ev[3]), .rx_ok_i(ev[4]), .bus_off_recover_i(ev[5]), .err_valid_i(ev[7]),
    .err_type_i(ety), .err_data_phase_i(edp), .err_is_tx_i(etx), .len_mismatch_i(ev[8]),
    .esi_rx_i(ev[9]), .msg_ok_i(ev[6]), .tx_bus_off_o(sto[3]), .tx_error_passive_o(sto[2]),
    .rx_error_passive_o(sto[1]), .any_warning_o(sto[0]));
  cesd_can_node i_cesd_can_node (.clk_sys_i(clk_sys_i), .ev_o(ev), .err_type_o(ety),
    .err_dp_o(edp), .err_tx_o(etx));
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one access held until waitrequest is seen low, then compared
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] b, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    @(posedge clk_sys_i) rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    be <= b;
    do @(posedge clk_sys_i); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    num_checks++;
    if (resp !== er || (!w && rdat !== exp)) begin
      bad_count++;
      $display("Error at %h: expected %h/%h seen %h/%h", a, exp, er, rdat, resp);
    end
  endtask
  // confinement state outputs, read as they stand before the current edge
  task automatic outs(input logic [3:0] exp);
    num_checks++;
    if (sto !== exp) begin
      bad_count++;
      $display("Error state outputs: expected %h seen %h", exp, sto);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    acc(1'b0, 4'h0, 32'h0, 4'hf, 32'h0020_0000);
    cfg <= 1'b0;
    acc(1'b0, 4'h0, 32'h0, 4'hf, 32'h0);
    acc(1'b0, 4'hc, 32'h0, 4'hf, 32'h0, cesd_pkg::RESP_SLVERR);
    i_cesd_can_node.pulse(0, 12);
    acc(1'b0, 4'h0, 32'h0, 4'hf, 32'h0005_6000);
    outs(4'h1);
    i_cesd_can_node.pulse(0, 4);
    acc(1'b0, 4'h0, 32'h0, 4'hf, 32'h0010_8000);
    i_cesd_can_node.pulse(0, 16);
    acc(1'b0, 4'h0, 32'h0, 4'hf, 32'h0030_0000);
    outs(4'hc);
    i_cesd_can_node.pulse(5, 1);
    acc(1'b0, 4'h8, 32'h0, 4'hf, 32'h0080_0000);
    i_cesd_can_node.pulse(3, 16);
    acc(1'b0, 4'h0, 32'h0, 4'hf, 32'h0008_0080);
    outs(4'h2);
    i_cesd_can_node.pulse(4, 1);
    acc(1'b1, 4'h0, 32'hffff_ffff, 4'hf, 32'h0);
    acc(1'b0, 4'h0, 32'h0, 4'hf, 32'h0003_0078);
    for (int t = 0; t < 6; t++) begin
      i_cesd_can_node.perr(cesd_pkg::cesd_err_type'(t), 1'b0, 1'b1);
      if (t != 3) i_cesd_can_node.perr(cesd_pkg::cesd_err_type'(t), 1'b1, 1'b0);
    end
    i_cesd_can_node.pulse(8, 1);
    i_cesd_can_node.pulse(9, 1);
    i_cesd_can_node.pulse(6, 3);
    acc(1'b0, 4'h8, 32'h0, 4'hf, 32'hfbbf_0003);
    acc(1'b0, 4'h4, 32'h0, 4'hf, 32'h0005_0600);
    acc(1'b1, 4'h8, 32'h4440_1234, 4'hf, 32'h0);
    acc(1'b0, 4'h8, 32'h0, 4'hf, 32'h4000_1234);
    acc(1'b1, 4'h4, 32'hffee_0201, 4'h5, 32'h0);
    acc(1'b0, 4'h4, 32'h0, 4'hf, 32'h00ee_0601);
    i_cesd_can_node.pulse(0, 1);
    i_cesd_can_node.pulse(1, 2);
    i_cesd_can_node.pulse(2, 2);
    cfg <= 1'b1;
    acc(1'b0, 4'h0, 32'h0, 4'hf, 32'h0023_067a);
    outs(4'h9);
    give_verdict();
  end
  // cut a hang short well past the expected run length
  initial begin
    #40000;
    bad_count++;
    give_verdict();
  end
endmodule
